// *** common/sps_pkg.sv ***
/*
  types shared by the power scaling engine files.
  assumes nothing beyond a standard SystemVerilog elaborator.
*/
package sps_pkg;
  typedef enum logic [1:0] {
    SPS_IDLE,
    SPS_CUR,
    SPS_PWR
  } sps_state_e;

  typedef logic [15:0] sps_word_t;
endpackage

// *** common/sps_regs.svh ***
/*
  register offsets, reset values and arithmetic constants of the power scaling engine.
  assumes inclusion by bare name from the design files.
*/
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH

`define SPS_OFS_SETUP      8'h00
`define SPS_OFS_SHUNT      8'h01
`define SPS_OFS_BUS        8'h02
`define SPS_OFS_POWER      8'h03
`define SPS_OFS_CURRENT    8'h04
`define SPS_OFS_SCALE      8'h05

`define SPS_SETUP_RESET    16'h4127
`define SPS_SCALE_RESET    16'h0000
`define SPS_RESULT_RESET   16'h0000

`define SPS_CUR_DIV        2048
`define SPS_PWR_DIV        20000
`define SPS_BUS_MSB        15
`define SPS_DIV_CYCLES     34

`endif

// *** testbench/sps_engine_asserts.sv ***
/*
  port assertions for the scaling engine.
  assumes bind onto sps_engine, one clock.
*/
module sps_engine_chk (
  // clock and reset
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  // watched ports
  input wire logic        bus_vld_i,
  input wire logic [7:0]  reg_ptr_i,
  input wire logic        reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        power_upd_o,
  input wire logic [15:0] power_o,
  input wire logic [15:0] current_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic cal_q;
  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i) cal_q <= 1'b0;
    else if (reg_wr_i && reg_ptr_i == 8'h05) cal_q <= 1'b1;
  sequence s_start; bus_vld_i && cal_q; endsequence
  sequence s_done; power_upd_o ##1 !power_upd_o; endsequence
  a_zero_uncal: assert property (!cal_q |-> !current_o && !power_o)
    else $error("result before scale");
  a_scale_back: assert property (reg_wr_i && reg_ptr_i == 8'h05 ##1
    reg_ptr_i == 8'h05 |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("scale");
  a_ptr_power: assert property (reg_ptr_i == 8'h03 ##1 $stable(power_o)
    |-> reg_rdata_o == power_o) else $error("ptr 03");
  a_ptr_current: assert property (reg_ptr_i == 8'h04 ##1 $stable(current_o)
    |-> reg_rdata_o == current_o) else $error("ptr 04");
  a_bus_msb: assert property (reg_ptr_i == 8'h02 |=> !reg_rdata_o[15])
    else $error("bus msb");
  a_upd_pulse: assert property (power_upd_o |-> s_done) else $error("pulse");
  a_pwr_latency: assert property (s_start |-> ##[36:72] power_upd_o)
    else $error("no power update");
  a_pwr_moves: assert property ($changed(power_o) |-> power_upd_o)
    else $error("power moved");
endmodule

bind sps_engine sps_engine_chk u_chk (.clk_sys_i, .rst_i, .bus_vld_i, .reg_ptr_i,
  .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .power_upd_o, .power_o, .current_o);

// *** testbench/sps_host.sv ***
/*
  host model: register write and read cycles.
  assumes rising-edge sampling, one-cycle read latency.
*/
module sps_host (
  // clock
  input  wire logic        clk_sys_i,
  // register access
  output logic [7:0]       ptr_o,
  output logic             wr_o,
  output logic [15:0]      wdata_o,
  input  wire logic [15:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ptr_o = 8'h00;
    wr_o = 1'b0;
    wdata_o = 16'h0000;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys_i);
    ptr_o = a;
    wr_o = 1'b1;
    wdata_o = d;
    @(negedge clk_sys_i);
    wr_o = 1'b0;
    wdata_o = ~d; // stale data never mimics a hold
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk_sys_i);
    ptr_o = a;
    repeat (2) @(negedge clk_sys_i);
    d = rdata_i;
  endtask
endmodule

// *** testbench/testbench.sv ***
/*
  self-checking bench for the scaling engine.
  assumes the host model drives the register side.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        shunt_vld_i = 1'b0;
  logic        bus_vld_i = 1'b0;
  logic [15:0] shunt_word_i = 16'h0000;
  logic [15:0] bus_word_i = 16'h0000;
  logic [7:0]  reg_ptr_i;
  logic        reg_wr_i;
  logic        power_upd_o;
  logic [15:0] reg_wdata_i, reg_rdata_o, power_o, current_o, v;
  int          err_total = 0;
  int          samples_checked = 0;
  // shunt, bus, current, power
  logic [15:0] tbl [4][4] = '{'{16'h1F40, 16'h2570, 16'h2710, 16'h12B8},
    '{16'hE0C0, 16'h2570, 16'hD8F0, 16'h12B8}, '{16'hFFFF, 16'h2570, 16'hFFFF, 16'h0000},
    '{16'h1F40, 16'hFFFF, 16'h2710, 16'h3FFF}};
  always #5 clk_sys_i = ~clk_sys_i;
  sps_engine uut (.clk_sys_i, .rst_i, .shunt_vld_i, .shunt_word_i, .bus_vld_i,
    .bus_word_i, .reg_ptr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .power_upd_o,
    .power_o, .current_o);
  sps_host host (.clk_sys_i, .ptr_o(reg_ptr_i), .wr_o(reg_wr_i), .wdata_o(reg_wdata_i),
    .rdata_i(reg_rdata_o));
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    host.rd(a, v);
    chk($sformatf("reg %h", a), e, v);
  endtask
  // bounded wait: no update comes while unscaled
  task automatic meas(input logic [15:0] s, input logic [15:0] b);
    @(negedge clk_sys_i);
    shunt_vld_i = 1'b1;
    shunt_word_i = s;
    @(negedge clk_sys_i);
    shunt_vld_i = 1'b0;
    bus_vld_i = 1'b1;
    bus_word_i = b;
    @(negedge clk_sys_i);
    bus_vld_i = 1'b0;
    for (int i = 0; i < 60 && power_upd_o !== 1'b1; i++) @(negedge clk_sys_i);
  endtask
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (3) @(negedge clk_sys_i);
    rst_i = 1'b0;
    rchk(8'h00, 16'h4127);
    rchk(8'h05, 16'h0000);
    rchk(8'h06, 16'h0000);
    meas(16'h1F40, 16'h2570);
    rchk(8'h04, 16'h0000);
    rchk(8'h03, 16'h0000);
    for (int a = 1; a < 5; a++) host.wr(a[7:0], 16'hFFFF);
    rchk(8'h01, 16'h1F40);
    rchk(8'h02, 16'h2570);
    rchk(8'h04, 16'h0000);
    host.wr(8'h05, 16'h0A00);
    rchk(8'h05, 16'h0A00);
    // pending bus word starts a compute on its own
    repeat (50) @(negedge clk_sys_i);
    for (int i = 0; i < 4; i++) begin
      meas(tbl[i][0], tbl[i][1]);
      chk("current", tbl[i][2], current_o);
      chk("power", tbl[i][3], power_o);
      rchk(8'h04, tbl[i][2]);
      rchk(8'h03, tbl[i][3]);
    end
    rchk(8'h02, 16'h7FFF);
    print_verdict();
  end
endmodule

// *** verilog/sps_divider.sv ***
/*
  unsigned restoring divider, one quotient bit per clock.
  assumes start is pulsed only while busy_o is low.
*/
`include "sps_regs.svh"

module sps_divider #(
  parameter int NUM_W = 32,
  parameter int DEN_W = 16
) (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  // request
  input  wire logic             start_i,
  input  wire logic [NUM_W-1:0] num_i,
  input  wire logic [DEN_W-1:0] den_i,
  // answer
  output logic                  busy_o,
  output logic                  done_o,
  output logic [NUM_W-1:0]      quot_o
);

  initial begin
    if (NUM_W < 2 || DEN_W < 2 || NUM_W > 40) $error("sps_divider: bad widths");
  end

  typedef struct packed {
    logic [NUM_W-1:0] quot;
    logic [DEN_W:0]   rem;
    logic [DEN_W-1:0] den;
    logic [5:0]       cnt;
    logic             busy;
    logic             done;
  } sps_div_s;

  sps_div_s s_q;
  sps_div_s s_d;

  always_comb begin
    logic [DEN_W+1:0] trial;
    trial = '0;
    s_d = s_q;
    s_d.done = 1'b0;
    if (s_q.busy) begin
      // shift in next numerator bit, subtract if it fits
      trial = {s_q.rem, s_q.quot[NUM_W-1]} - {2'b00, s_q.den};
      s_d.quot = {s_q.quot[NUM_W-2:0], ~trial[DEN_W+1]};
      if (!trial[DEN_W+1]) begin
        s_d.rem = trial[DEN_W:0];
      end else begin
        s_d.rem = {s_q.rem[DEN_W-1:0], s_q.quot[NUM_W-1]};
      end
      s_d.cnt = s_q.cnt - 6'h01;
      if (s_q.cnt == 6'h01) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
    end else if (start_i) begin
      s_d.quot = num_i;
      s_d.rem  = '0;
      s_d.den  = den_i;
      s_d.cnt  = 6'(NUM_W);
      s_d.busy = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy_o = s_q.busy;
  assign done_o = s_q.done;
  assign quot_o = s_q.quot;

endmodule

// *** verilog/sps_engine.sv ***
/*
  current and power scaling engine with its register file.
  assumes shunt and bus measurements arrive as one-cycle strobes from the converter and
  that register access comes from the serial-bus target logic as simple strobes.
*/
// Contract
// - current and power come from the scale factor and the two measured words.
// - current equals shunt word times scale factor divided by 2048.
// - power equals current magnitude times bus word divided by 20000.
// - power step is fixed at 25 times the current step by the constant divisors.
// - current and power read zero while the scale factor is unwritten.
// - once programmed, results refresh on every new bus word, whether or not a new shunt word has arrived.
// - bus word carries a fixed 1.25 mV per bit independent of the scale factor.
// - the top bit of the bus word always reads zero.
// - pointer 04h selects current and 03h selects power.
// - power is recomputed, for limit comparison, after every bus conversion.
`include "sps_regs.svh"

module sps_engine #(
  parameter int CUR_DIV = `SPS_CUR_DIV,
  parameter int PWR_DIV = `SPS_PWR_DIV
) (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // measurements from the converter
  input  wire logic        shunt_vld_i,
  input  wire logic [15:0] shunt_word_i,
  input  wire logic        bus_vld_i,
  input  wire logic [15:0] bus_word_i,
  // register access from the serial target
  input  wire logic [7:0]  reg_ptr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic [15:0]      reg_rdata_o,
  // results for the alert logic
  output logic             power_upd_o,
  output logic [15:0]      power_o,
  output logic [15:0]      current_o
);

  initial begin
    if (CUR_DIV != 2048 || PWR_DIV < 2 || PWR_DIV > 65535) $error("sps_engine: bad divisor");
  end

  typedef struct packed {
    sps_pkg::sps_state_e state;
    sps_pkg::sps_word_t  setup;
    sps_pkg::sps_word_t  shunt;
    sps_pkg::sps_word_t  bus;
    sps_pkg::sps_word_t  scale;
    sps_pkg::sps_word_t  current;
    sps_pkg::sps_word_t  power;
    sps_pkg::sps_word_t  rdata;
    logic                scale_set;
    logic                shunt_new;
    logic                bus_new;
    logic                start;
    logic                upd;
    logic [31:0]         num;
  } sps_eng_s;

  sps_eng_s s_q;
  sps_eng_s s_d;

  logic        div_busy;
  logic        div_done;
  logic [31:0] div_quot;
  logic [31:0] cur_prod;
  logic [31:0] cur_mag;
  logic [31:0] pwr_prod;
  logic [15:0] cur_abs;

  // shunt word is signed, scale factor unsigned
  assign cur_prod = 32'($signed(s_q.shunt) * $signed({1'b0, s_q.scale}));
  assign cur_mag  = cur_prod[31] ? 32'(-cur_prod) : cur_prod;
  // /2048 is a shift on the magnitude so truncation goes toward zero
  assign cur_abs  = cur_mag[26:11];
  assign pwr_prod = {16'h0000, cur_abs} * {16'h0000, s_q.bus};

  // power sign is dropped: power is reported as magnitude
  sps_divider #(
    .NUM_W (32),
    .DEN_W (16)
  ) u_div (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .start_i   (s_q.start),
    .num_i     (s_q.num),
    .den_i     (16'(PWR_DIV)),
    .busy_o    (div_busy),
    .done_o    (div_done),
    .quot_o    (div_quot)
  );

  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    s_d.upd   = 1'b0;
    if (shunt_vld_i) begin
      s_d.shunt     = shunt_word_i;
      s_d.shunt_new = 1'b1;
    end
    if (bus_vld_i) begin
      s_d.bus     = {1'b0, bus_word_i[14:0]};
      s_d.bus_new = 1'b1;
    end
    // host writes; result registers ignore writes
    if (reg_wr_i) begin
      if (reg_ptr_i == `SPS_OFS_SETUP) begin
        s_d.setup = reg_wdata_i;
      end else if (reg_ptr_i == `SPS_OFS_SCALE) begin
        s_d.scale     = reg_wdata_i;
        s_d.scale_set = 1'b1;
      end
    end
    case (s_q.state)
      sps_pkg::SPS_IDLE: begin
        // refresh whenever a bus conversion is pending; shunt_new is not checked
        if (s_q.scale_set && s_q.bus_new && !div_busy) begin
          s_d.bus_new   = bus_vld_i;
          s_d.shunt_new = shunt_vld_i;
          s_d.state     = sps_pkg::SPS_CUR;
        end
      end
      sps_pkg::SPS_CUR: begin
        s_d.current = cur_prod[31] ? 16'(-{16'h0000, cur_abs}) : cur_abs;
        s_d.num     = pwr_prod;
        s_d.start   = 1'b1;
        s_d.state   = sps_pkg::SPS_PWR;
      end
      sps_pkg::SPS_PWR: begin
        if (div_done) begin
          s_d.power = div_quot[15:0];
          s_d.upd   = 1'b1;
          s_d.state = sps_pkg::SPS_IDLE;
        end
      end
      default: begin
        s_d.state = sps_pkg::SPS_IDLE;
      end
    endcase
    // read mux, registered
    if (reg_ptr_i == `SPS_OFS_SETUP) begin
      s_d.rdata = s_q.setup;
    end else if (reg_ptr_i == `SPS_OFS_SHUNT) begin
      s_d.rdata = s_q.shunt;
    end else if (reg_ptr_i == `SPS_OFS_BUS) begin
      s_d.rdata = s_q.bus;
    end else if (reg_ptr_i == `SPS_OFS_POWER) begin
      s_d.rdata = s_q.scale_set ? s_q.power : `SPS_RESULT_RESET;
    end else if (reg_ptr_i == `SPS_OFS_CURRENT) begin
      s_d.rdata = s_q.scale_set ? s_q.current : `SPS_RESULT_RESET;
    end else if (reg_ptr_i == `SPS_OFS_SCALE) begin
      s_d.rdata = s_q.scale;
    end else begin
      s_d.rdata = 16'h0000;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_q       <= '0;
      s_q.state <= sps_pkg::SPS_IDLE;
      s_q.setup <= `SPS_SETUP_RESET;
      s_q.scale <= `SPS_SCALE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o = s_q.rdata;
  assign power_upd_o = s_q.upd;
  assign power_o     = s_q.power;
  assign current_o   = s_q.current;

endmodule
